// File: rtl/gpio_bank_defs.vh
`ifndef GPIO_BANK_DEFS_VH
`define GPIO_BANK_DEFS_VH

// Register indices; the bus byte address is four times the index.
`define IDX_A_DATA   4'h0
`define IDX_B_DATA   4'h1
`define IDX_C_DATA   4'h2
`define IDX_D_DATA   4'h3
`define IDX_A_DIR    4'h4
`define IDX_B_DIR    4'h5
`define IDX_C_DIR    4'h6
`define IDX_D_DIR    4'h7
`define IDX_E_DATA   4'h8
`define IDX_E_DIR    4'hC
`define IDX_A_PULLUP 4'hD
`define IDX_C_PULLUP 4'hE
`define IDX_D_PULLUP 4'hF

// Address decode fields.
`define ADDR_W       16
`define IDX_LSB      2
`define IDX_MSB      5

// Implemented bit masks.
`define MASK_FULL    8'hFF
`define MASK_C       8'h7F
`define MASK_E       8'h3F

// Reset values.
`define DIR_RESET    8'h00
`define PULLUP_RESET 8'h00

// Shared peripheral pin positions.
`define CONV_PINS    5'h08
`define SPI_LSB      0
`define TIMER_LSB    4
`define SCI_TX_BIT   0
`define SCI_RX_BIT   1

// Bus answers.
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// File: rtl/gpio_five_port_bank.v
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "gpio_bank_defs.vh"
module gpio_five_port_bank (
	// System
	input  wire              clk_sys,
	input  wire              rst,
	// AXI4-Lite write address
	input  wire [15:0]       s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]        s_axi_bresp,
	output wire              s_axi_bvalid,
	input  wire              s_axi_bready,
	// AXI4-Lite read address
	input  wire [15:0]       s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0]       s_axi_rdata,
	output wire [1:0]        s_axi_rresp,
	output wire              s_axi_rvalid,
	input  wire              s_axi_rready,
	// Port A pins
	input  wire [7:0]        portAIn,
	output wire [7:0]        portAOut,
	output wire [7:0]        portAOe,
	output wire [7:0]        portAPullup,
	// Port B pins
	input  wire [7:0]        portBIn,
	output wire [7:0]        portBOut,
	output wire [7:0]        portBOe,
	// Port C pins
	input  wire [6:0]        portCIn,
	output wire [6:0]        portCOut,
	output wire [6:0]        portCOe,
	output wire [6:0]        portCPullup,
	// Port D pins
	input  wire [7:0]        portDIn,
	output wire [7:0]        portDOut,
	output wire [7:0]        portDOe,
	output wire [7:0]        portDPullup,
	// Port E pins
	input  wire [5:0]        portEIn,
	output wire [5:0]        portEOut,
	output wire [5:0]        portEOe,
	// Keypad interrupt unit
	input  wire [7:0]        keypadIrqEnables,
	output wire [7:0]        keypadInputs,
	// Converter
	input  wire [4:0]        converterChannelSelect,
	// Serial peripheral
	input  wire              serialPeriphEnable,
	input  wire [3:0]        spiPinOut,
	input  wire [3:0]        spiPinOe,
	// Timers, two select bits per channel
	input  wire [7:0]        timerEdgeLevelSelect,
	input  wire [3:0]        timerPinOut,
	input  wire [3:0]        timerPinOe,
	// Asynchronous serial
	input  wire              asyncSerialEnable,
	input  wire              sciTxData
);
	// Bus state
	reg  [15:0] awAddr_r;
	reg         awFull_r;
	reg  [7:0]  wData_r;
	reg         wLane0_r;
	reg         wFull_r;
	reg         bValid_r;
	reg  [1:0]  bResp_r;
	reg  [31:0] rData_r;
	reg  [1:0]  rResp_r;
	reg         rValid_r;
	reg  [7:0]  keypadInputs_r;
	reg  [7:0]  readMux;
	wire        doWrite;
	wire        wrOk;
	wire [3:0]  wrIdx;
	wire [3:0]  rdIdx;

	// Register contents
	wire [7:0]  portADataLatch;
	wire [7:0]  portBDataLatch;
	wire [7:0]  portCDataLatch;
	wire [7:0]  portDDataLatch;
	wire [7:0]  portEDataLatch;
	wire [7:0]  portADirection;
	wire [7:0]  portBDirection;
	wire [7:0]  portCDirection;
	wire [7:0]  portDDirection;
	wire [7:0]  portEDirection;
	wire [7:0]  portAPullupEnable;
	wire [7:0]  portCPullupEnable;
	wire [7:0]  portDPullupEnable;

	// Pin-side views
	wire [7:0]  readA;
	wire [7:0]  readB;
	wire [7:0]  readC;
	wire [7:0]  readD;
	wire [7:0]  readE;
	wire [7:0]  cOut;
	wire [7:0]  cOe;
	wire [7:0]  cPull;
	wire [7:0]  eOut;
	wire [7:0]  eOe;
	wire [7:0]  ovB;
	wire [7:0]  ovD;
	wire [7:0]  ovE;
	wire [7:0]  ovDOut;
	wire [7:0]  ovDOe;
	wire [7:0]  ovEOut;
	wire [3:0]  timerOn;

	function [3:0] regIdx;
		input [15:0] addr;
		begin
			regIdx = addr[`IDX_MSB:`IDX_LSB];
		end
	endfunction

	// Indices 9 to B and anything above the map answer with an error.
	function isMapped;
		input [15:0] addr;
		begin
			isMapped = (addr[15:`IDX_MSB+1] == 10'h000) &&
				!((addr[`IDX_MSB:`IDX_LSB] > `IDX_E_DATA) &&
				(addr[`IDX_MSB:`IDX_LSB] < `IDX_E_DIR));
		end
	endfunction

	// Address and data are taken independently and held until both are in.
	assign s_axi_awready = !awFull_r && !bValid_r;
	assign s_axi_wready  = !wFull_r && !bValid_r;
	assign s_axi_bvalid  = bValid_r;
	assign s_axi_bresp   = bResp_r;
	assign s_axi_arready = !rValid_r;
	assign s_axi_rvalid  = rValid_r;
	assign s_axi_rdata   = rData_r;
	assign s_axi_rresp   = rResp_r;

	assign doWrite = awFull_r && wFull_r;
	assign wrIdx   = regIdx(awAddr_r);
	assign wrOk    = doWrite && wLane0_r && isMapped(awAddr_r);
	assign rdIdx   = regIdx(s_axi_araddr);

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awAddr_r <= 16'h0000;
			awFull_r <= 1'b0;
			wData_r  <= 8'h00;
			wLane0_r <= 1'b0;
			wFull_r  <= 1'b0;
			bValid_r <= 1'b0;
			bResp_r  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_r <= s_axi_awaddr;
				awFull_r <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_r  <= s_axi_wdata[7:0];
				wLane0_r <= s_axi_wstrb[0];
				wFull_r  <= 1'b1;
			end
			if (doWrite) begin
				awFull_r <= 1'b0;
				wFull_r  <= 1'b0;
				bValid_r <= 1'b1;
				bResp_r  <= isMapped(awAddr_r) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bValid_r && s_axi_bready) begin
				bValid_r <= 1'b0;
			end
		end
	end

	always @* begin
		case (rdIdx)
			`IDX_A_DATA:   readMux = readA;
			`IDX_B_DATA:   readMux = readB;
			`IDX_C_DATA:   readMux = readC & `MASK_C;
			`IDX_D_DATA:   readMux = readD;
			`IDX_A_DIR:    readMux = portADirection;
			`IDX_B_DIR:    readMux = portBDirection;
			`IDX_C_DIR:    readMux = portCDirection;
			`IDX_D_DIR:    readMux = portDDirection;
			`IDX_E_DATA:   readMux = readE & `MASK_E;
			`IDX_E_DIR:    readMux = portEDirection;
			`IDX_A_PULLUP: readMux = portAPullupEnable;
			`IDX_C_PULLUP: readMux = portCPullupEnable;
			`IDX_D_PULLUP: readMux = portDPullupEnable;
			default:       readMux = 8'h00;
		endcase
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rData_r  <= 32'h00000000;
			rResp_r  <= `RESP_OKAY;
			rValid_r <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rData_r  <= isMapped(s_axi_araddr) ? {24'h000000, readMux} : 32'h00000000;
			rResp_r  <= isMapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			rValid_r <= 1'b1;
		end else if (rValid_r && s_axi_rready) begin
			rValid_r <= 1'b0;
		end
	end

	// Data latches: no reset, written whatever the direction.
	masked_reg #(.MASK(`MASK_FULL), .RESET_VAL(8'h00), .HAS_RESET(0)) u_aData (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_A_DATA),
		.wrData(wData_r), .value(portADataLatch));
	masked_reg #(.MASK(`MASK_FULL), .RESET_VAL(8'h00), .HAS_RESET(0)) u_bData (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_B_DATA),
		.wrData(wData_r), .value(portBDataLatch));
	masked_reg #(.MASK(`MASK_C), .RESET_VAL(8'h00), .HAS_RESET(0)) u_cData (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_C_DATA),
		.wrData(wData_r), .value(portCDataLatch));
	masked_reg #(.MASK(`MASK_FULL), .RESET_VAL(8'h00), .HAS_RESET(0)) u_dData (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_D_DATA),
		.wrData(wData_r), .value(portDDataLatch));
	masked_reg #(.MASK(`MASK_E), .RESET_VAL(8'h00), .HAS_RESET(0)) u_eData (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_E_DATA),
		.wrData(wData_r), .value(portEDataLatch));

	// Direction and pullup enables clear on reset, so every pin not taken over by a peripheral starts as an input.
	masked_reg #(.MASK(`MASK_FULL), .RESET_VAL(`DIR_RESET), .HAS_RESET(1)) u_aDir (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_A_DIR),
		.wrData(wData_r), .value(portADirection));
	masked_reg #(.MASK(`MASK_FULL), .RESET_VAL(`DIR_RESET), .HAS_RESET(1)) u_bDir (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_B_DIR),
		.wrData(wData_r), .value(portBDirection));
	masked_reg #(.MASK(`MASK_C), .RESET_VAL(`DIR_RESET), .HAS_RESET(1)) u_cDir (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_C_DIR),
		.wrData(wData_r), .value(portCDirection));
	masked_reg #(.MASK(`MASK_FULL), .RESET_VAL(`DIR_RESET), .HAS_RESET(1)) u_dDir (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_D_DIR),
		.wrData(wData_r), .value(portDDirection));
	masked_reg #(.MASK(`MASK_E), .RESET_VAL(`DIR_RESET), .HAS_RESET(1)) u_eDir (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_E_DIR),
		.wrData(wData_r), .value(portEDirection));
	masked_reg #(.MASK(`MASK_FULL), .RESET_VAL(`PULLUP_RESET), .HAS_RESET(1)) u_aPu (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_A_PULLUP),
		.wrData(wData_r), .value(portAPullupEnable));
	masked_reg #(.MASK(`MASK_C), .RESET_VAL(`PULLUP_RESET), .HAS_RESET(1)) u_cPu (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_C_PULLUP),
		.wrData(wData_r), .value(portCPullupEnable));
	masked_reg #(.MASK(`MASK_FULL), .RESET_VAL(`PULLUP_RESET), .HAS_RESET(1)) u_dPu (
		.clk_sys(clk_sys), .rst(rst), .wrEn(wrOk && wrIdx == `IDX_D_PULLUP),
		.wrData(wData_r), .value(portDPullupEnable));

	// The selected converter channel floats its pin; channels past seven touch no pin.
	assign ovB = (converterChannelSelect < `CONV_PINS) ?
		(8'h01 << converterChannelSelect[2:0]) : 8'h00;
	genvar t;
	generate
		for (t = 0; t < 4; t = t + 1) begin : g_tim
			assign timerOn[t] = |timerEdgeLevelSelect[2*t+1:2*t];
		end
	endgenerate
	assign ovD    = {timerOn, {4{serialPeriphEnable}}};
	assign ovDOut = {timerPinOut, spiPinOut};
	assign ovDOe  = {timerPinOe, spiPinOe};
	// The receive pin of the asynchronous serial unit is held as an input.
	assign ovE    = {6'h00, asyncSerialEnable, asyncSerialEnable};
	assign ovEOut = {7'h00, sciTxData};
	assign portCOut    = cOut[6:0];
	assign portCOe     = cOe[6:0];
	assign portCPullup = cPull[6:0];
	assign portEOut    = eOut[5:0];
	assign portEOe     = eOe[5:0];

	gpio_pin_port u_portA (
		.latch    (portADataLatch),
		.dir      (portADirection),
		.pullupEn (portAPullupEnable),
		.pinIn    (portAIn),
		.ovMask   (8'h00),
		.ovOut    (8'h00),
		.ovOe     (8'h00),
		.pinOut   (portAOut),
		.pinOe    (portAOe),
		.pullupOn (portAPullup),
		.readVal  (readA)
	);
	gpio_pin_port u_portB (
		.latch    (portBDataLatch),
		.dir      (portBDirection),
		.pullupEn (8'h00),
		.pinIn    (portBIn),
		.ovMask   (ovB),
		.ovOut    (8'h00),
		.ovOe     (8'h00),
		.pinOut   (portBOut),
		.pinOe    (portBOe),
		.pullupOn (),
		.readVal  (readB)
	);
	gpio_pin_port u_portC (
		.latch    (portCDataLatch),
		.dir      (portCDirection),
		.pullupEn (portCPullupEnable),
		.pinIn    ({1'b0, portCIn}),
		.ovMask   (8'h00),
		.ovOut    (8'h00),
		.ovOe     (8'h00),
		.pinOut   (cOut),
		.pinOe    (cOe),
		.pullupOn (cPull),
		.readVal  (readC)
	);
	gpio_pin_port u_portD (
		.latch    (portDDataLatch),
		.dir      (portDDirection),
		.pullupEn (portDPullupEnable),
		.pinIn    (portDIn),
		.ovMask   (ovD),
		.ovOut    (ovDOut),
		.ovOe     (ovDOe),
		.pinOut   (portDOut),
		.pinOe    (portDOe),
		.pullupOn (portDPullup),
		.readVal  (readD)
	);
	gpio_pin_port u_portE (
		.latch    (portEDataLatch),
		.dir      (portEDirection),
		.pullupEn (8'h00),
		.pinIn    ({2'h0, portEIn}),
		.ovMask   (ovE),
		.ovOut    (ovEOut),
		.ovOe     (ovE & 8'h01),
		.pinOut   (eOut),
		.pinOe    (eOe),
		.pullupOn (),
		.readVal  (readE)
	);

	// Keypad lines follow the pin level whatever the direction, gated by their enable.
	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			keypadInputs_r <= 8'h00;
		else
			keypadInputs_r <= portAIn & keypadIrqEnables;
	end
	assign keypadInputs = keypadInputs_r;

	// Loading the latch before raising a direction bit is left to software.
endmodule // gpio_five_port_bank

// File: rtl/gpio_pin_port.v
`timescale 1ns/1ns
module gpio_pin_port (
	// Port registers
	input  wire [7:0] latch,
	input  wire [7:0] dir,
	input  wire [7:0] pullupEn,
	// Pin levels
	input  wire [7:0] pinIn,
	// Shared peripheral takeover
	input  wire [7:0] ovMask,
	input  wire [7:0] ovOut,
	input  wire [7:0] ovOe,
	// Pin drive
	output wire [7:0] pinOut,
	output wire [7:0] pinOe,
	output wire [7:0] pullupOn,
	// Value seen by a data read
	output wire [7:0] readVal
);
	wire [7:0] ownsOut;

	assign pinOut   = (ovMask & ovOut) | (~ovMask & latch);
	assign pinOe    = (ovMask & ovOe) | (~ovMask & dir);
	assign pullupOn = pullupEn & ~dir;
	// A pin the port does not drive is read at its level, never from the latch.
	assign ownsOut  = dir & ~ovMask;
	assign readVal  = (ownsOut & latch) | (~ownsOut & pinIn);
endmodule // gpio_pin_port

// File: rtl/masked_reg.v
`timescale 1ns/1ns
module masked_reg #(
	parameter [7:0] MASK      = 8'hFF,
	parameter [7:0] RESET_VAL = 8'h00,
	parameter       HAS_RESET = 1
) (
	// System
	input  wire       clk_sys,
	input  wire       rst,
	// Write port
	input  wire       wrEn,
	input  wire [7:0] wrData,
	// Contents
	output wire [7:0] value
);
	reg [7:0] value_r;

	// Unimplemented bits never store and always read zero.
	assign value = value_r & MASK;

	generate
		if (HAS_RESET) begin : g_rst
			always @(posedge clk_sys or posedge rst) begin
				if (rst)
					value_r <= RESET_VAL;
				else if (wrEn)
					value_r <= wrData & MASK;
			end
		end else begin : g_keep
			// Data latches keep their contents across reset.
			always @(posedge clk_sys) begin
				if (wrEn)
					value_r <= wrData & MASK;
			end
		end
	endgenerate
endmodule // masked_reg

// File: sim/gpio_bank_sva.sv
`timescale 1ns/1ns
module gpio_bank_sva (
	// System
	input wire logic        clk_sys,
	input wire logic        rst,
	// Register bus
	input wire logic [15:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// Port A and keypad
	input wire logic [7:0]  portAIn,
	input wire logic [7:0]  portAOut,
	input wire logic [7:0]  portAOe,
	input wire logic [7:0]  portAPullup,
	input wire logic [7:0]  keypadIrqEnables,
	input wire logic [7:0]  keypadInputs
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rdPortA;
		rdTaken ##0 (s_axi_araddr == 16'h0000);
	endsequence
	AST_OE_RESET: assert property ($fell(rst) |-> portAOe == 8'h00)
		else $error("direction not cleared by reset");
	AST_OE_WRITE: assert property (!$rose(s_axi_bvalid) |-> $stable(portAOe))
		else $error("drive enable moved without a write");
	AST_READ_PORT_A: assert property (rdPortA |=> s_axi_rdata[7:0] ==
		(($past(portAOe) & $past(portAOut)) | (~$past(portAOe) & $past(portAIn))))
		else $error("port read mixes latch and pin wrongly");
	AST_PULLUP_OUT: assert property ((portAPullup & portAOe) == 8'h00)
		else $error("pullup on a driven pin");
	AST_KEYPAD: assert property (!rst |=> keypadInputs ==
		($past(portAIn) & $past(keypadIrqEnables)))
		else $error("keypad routing wrong");
	AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	AST_READ_ANSWER: assert property (rdTaken |=> s_axi_rvalid)
		else $error("read not answered");
	AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
endmodule // gpio_bank_sva

bind gpio_five_port_bank gpio_bank_sva chk (
	.clk_sys(clk_sys), .rst(rst), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe), .portAPullup(portAPullup),
	.keypadIrqEnables(keypadIrqEnables), .keypadInputs(keypadInputs));

// File: sim/pin_side_model.sv
`timescale 1ns/1ns
module pin_side_model (
	// Clock
	input wire logic        clk_sys,
	// Design side
	input wire logic [7:0]  pinOut,
	input wire logic [7:0]  pinOe,
	input wire logic [7:0]  pullupOn,
	// Outside drivers
	input wire logic [7:0]  extLevel,
	input wire logic [7:0]  extEn,
	// Pin levels
	output logic [7:0]      pinLevel
);
	// A floating pin toggles so a stale level can never pass for a read.
	logic [7:0] floatPat = 8'h55;
	always @(posedge clk_sys) begin
		floatPat <= ~floatPat;
	end
	always_comb begin
		pinLevel = (pinOe & pinOut) | (~pinOe & extEn & extLevel)
			| (~pinOe & ~extEn & pullupOn)
			| (~pinOe & ~extEn & ~pullupOn & floatPat);
	end
endmodule // pin_side_model

// File: sim/tb_gpio_five_port_bank.sv
`timescale 1ns/1ns
`include "gpio_bank_defs.vh"
module tb_gpio_five_port_bank;
	reg         clk_sys = 1'b0;
	reg         rst = 1'b1;
	reg  [15:0] s_axi_awaddr = 16'h0000;
	reg  [15:0] s_axi_araddr = 16'h0000;
	reg  [31:0] s_axi_wdata = 32'h00000000;
	reg         s_axi_awvalid = 1'b0;
	reg         s_axi_wvalid = 1'b0;
	reg         s_axi_bready = 1'b0;
	reg         s_axi_arvalid = 1'b0;
	reg         s_axi_rready = 1'b0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0]  portAIn, portAOut, portAOe, portAPullup, keypadInputs, portBOe, portDOut, portDOe;
	wire [5:0]  portEOut, portEOe;
	reg  [7:0]  extLevel = 8'h00;
	reg  [7:0]  extEn = 8'h00;
	reg  [7:0]  keyEn = 8'h00;
	reg  [7:0]  misc = 8'h00;
	reg  [4:0]  convSel = 5'h1F;
	reg         spiEn = 1'b0;
	reg  [31:0] rdat;
	reg  [1:0]  resp;
	integer     failures = 0;
	integer     checks = 0;
	integer     cycles = 0;

	gpio_five_port_bank uut (
		.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .portAIn(portAIn), .portAOut(portAOut),
		.portAOe(portAOe), .portAPullup(portAPullup), .portBIn(misc), .portBOut(),
		.portBOe(portBOe), .portCIn(misc[6:0]), .portCOut(), .portCOe(), .portCPullup(),
		.portDIn(misc), .portDOut(portDOut), .portDOe(portDOe), .portDPullup(),
		.portEIn(misc[5:0]), .portEOut(portEOut), .portEOe(portEOe), .keypadIrqEnables(keyEn),
		.keypadInputs(keypadInputs), .converterChannelSelect(convSel),
		.serialPeriphEnable(spiEn), .spiPinOut(misc[3:0]), .spiPinOe(misc[7:4]),
		.timerEdgeLevelSelect(misc), .timerPinOut(misc[3:0]), .timerPinOe(misc[7:4]),
		.asyncSerialEnable(spiEn), .sciTxData(misc[0]));

	pin_side_model pins (
		.clk_sys(clk_sys), .pinOut(portAOut), .pinOe(portAOe), .pullupOn(portAPullup),
		.extLevel(extLevel), .extEn(extEn), .pinLevel(portAIn));

	initial begin
		forever #25 clk_sys = ~clk_sys;
	end

	function [15:0] ba(input [3:0] idx);
		ba = {10'h000, idx, 2'b00};
	endfunction

	task chk(input [31:0] got, input [31:0] exp, input string what);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
			end
		end
	endtask

	task wr(input [15:0] a, input [7:0] d);
		reg aw, w, b;
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h000000, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			b = 1'b0;
			while (!b) begin
				@(posedge clk_sys);
				aw = s_axi_awvalid & s_axi_awready;
				w = s_axi_wvalid & s_axi_wready;
				b = s_axi_bvalid & s_axi_bready;
				resp = s_axi_bresp;
				if (aw) s_axi_awvalid <= 1'b0;
				if (w) s_axi_wvalid <= 1'b0;
			end
			s_axi_bready <= 1'b0;
			@(posedge clk_sys);
		end
	endtask

	task rd(input [15:0] a);
		reg ar, r;
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			r = 1'b0;
			while (!r) begin
				@(posedge clk_sys);
				ar = s_axi_arvalid & s_axi_arready;
				r = s_axi_rvalid & s_axi_rready;
				rdat = s_axi_rdata;
				resp = s_axi_rresp;
				if (ar) s_axi_arvalid <= 1'b0;
			end
			s_axi_rready <= 1'b0;
			@(posedge clk_sys);
		end
	endtask

	task wrChk(input [15:0] a, input [7:0] d);
		begin
			wr(a, d);
			chk(resp, `RESP_OKAY, "bresp");
		end
	endtask

	task rdChk(input [15:0] a, input [31:0] exp, input string what);
		begin
			rd(a);
			chk(rdat, exp, what);
			chk(resp, `RESP_OKAY, "rresp");
		end
	endtask

	task give_verdict;
		begin
			$display("checks %0d failures %0d", checks, failures);
			if (failures == 0 && checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	// The whole run needs about a hundred cycles; this ceiling catches a hang.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures = failures + 1;
			give_verdict;
		end
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rdChk(ba(`IDX_A_DIR), 32'h00, "dir A reset");
		rdChk(ba(`IDX_A_PULLUP), 32'h00, "pullup reset");
		chk(portAOe, 8'h00, "oe reset");
		$display("done: reset values");
		extEn <= 8'hFF;
		extLevel <= 8'h96;
		wrChk(ba(`IDX_A_DATA), 8'h5A);
		wrChk(ba(`IDX_A_DIR), 8'hF0);
		chk(portAOe, 8'hF0, "oe A");
		chk(portAOut, 8'h5A, "out A");
		rdChk(ba(`IDX_A_DATA), 32'h56, "mixed read");
		wrChk(ba(`IDX_A_DATA), 8'h3C);
		rdChk(ba(`IDX_A_DATA), 32'h36, "latch write");
		wrChk(ba(`IDX_A_DIR), 8'h00);
		rdChk(ba(`IDX_A_DATA), 32'h96, "pin read");
		wrChk(ba(`IDX_A_DIR), 8'hFF);
		rdChk(ba(`IDX_A_DATA), 32'h3C, "stored input bits");
		$display("done: data and direction");
		extEn <= 8'h00;
		wrChk(ba(`IDX_A_PULLUP), 8'hFF);
		wrChk(ba(`IDX_A_DIR), 8'hF0);
		chk(portAPullup, 8'h0F, "pullup inputs only");
		rdChk(ba(`IDX_A_DATA), 32'h3F, "pulled pins");
		$display("done: pullups");
		keyEn <= 8'hA5;
		repeat (3) @(negedge clk_sys);
		chk(keypadInputs, 8'h25, "keypad inputs");
		@(posedge clk_sys);
		$display("done: keypad");
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk(portAOut, 8'h3C, "latch after reset");
		chk(portAOe, 8'h00, "oe after reset");
		rdChk(ba(`IDX_A_PULLUP), 32'h00, "pullup after reset");
		$display("done: second reset");
		wrChk(ba(`IDX_C_DIR), 8'hFF);
		rdChk(ba(`IDX_C_DIR), 32'h7F, "dir C width");
		wrChk(ba(`IDX_E_DIR), 8'hFF);
		rdChk(ba(`IDX_E_DIR), 32'h3F, "dir E width");
		wr(ba(4'h9), 8'hFF);
		chk(resp, `RESP_SLVERR, "unmapped write");
		rd(ba(4'h9));
		chk(rdat, 32'h00000000, "unmapped read data");
		chk(resp, `RESP_SLVERR, "unmapped read");
		$display("done: unimplemented bits");
		misc <= 8'hFA;
		convSel <= 5'h03;
		spiEn <= 1'b1;
		wrChk(ba(`IDX_B_DIR), 8'hFF);
		chk(portBOe, 8'hF7, "converter pin");
		chk(portDOut, 8'hAA, "serial and timer pins");
		chk(portDOe, 8'hFF, "serial and timer enables");
		chk(portEOe, 6'h3D, "async serial enables");
		chk(portEOut[1:0], 2'h0, "async serial pins");
		$display("done: shared peripherals");
		give_verdict;
	end
endmodule // tb_gpio_five_port_bank
